/* shared/core_mem_pkg.sv */
/*
  package for the core memory cycle controller: timing constants, state
  encoding and the request/answer carriers.
  assumes a 20 MHz system clock.
*/
package core_mem_pkg;

  // ==================================================================
  // geometry
  localparam int unsigned WORD_W      = 12;
  localparam int unsigned BANK_ADDR_W = 12;
  localparam int unsigned ADDR_W      = 13;
  localparam int unsigned BANK_WORDS  = 4096;
  localparam int unsigned MAX_WORDS   = 8192;

  // ==================================================================
  // timing
  localparam int unsigned CLK_PERIOD_PS  = 50000;
  localparam int unsigned CYCLE_TIME_PS  = 1690000;
  localparam int unsigned ACCESS_TIME_PS = 530000;
  localparam int unsigned WDATA_TIME_PS  = 700000;
  // least time: round up
  localparam int unsigned CYCLE_CLKS  = (CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // longest times: round down, at least one cycle
  localparam int unsigned ACCESS_CLKS = (ACCESS_TIME_PS / CLK_PERIOD_PS) > 0 ?
                                        (ACCESS_TIME_PS / CLK_PERIOD_PS) : 1;
  localparam int unsigned WDATA_CLKS  = (WDATA_TIME_PS / CLK_PERIOD_PS) > 0 ?
                                        (WDATA_TIME_PS / CLK_PERIOD_PS) : 1;
  localparam int unsigned CNT_W = 6;

  // ==================================================================
  // reset values
  localparam logic [WORD_W-1:0] WORD_RESET = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;

  // ==================================================================
  // states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FIRST = 4'b0010,
    ST_LAST  = 4'b0100,
    ST_DONE  = 4'b1000
  } state_t;

  // ==================================================================
  // carriers
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic              done;
    logic [WORD_W-1:0] rdata;
  } mem_rsp_t;

  typedef struct packed {
    logic                   start;
    logic                   write;
    logic                   bank_sel;
    logic [BANK_ADDR_W-1:0] addr;
    logic [WORD_W-1:0]      work;
    logic                   work_drive;
  } core_pins_t;

endpackage : core_mem_pkg

/* verilog/sense_capture.sv */
/*
  sense capture: synchronises the twelve sense amplifier outputs and sets
  bits of the working register image when a pulse is seen while the window is open.
  assumes sense pulses are at least three system clocks long.
*/
`timescale 1ns/10ps
module sense_capture #(
  parameter int unsigned WIDTH = 12
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // control
  input  wire logic             window,
  // sense inputs
  input  wire logic [WIDTH-1:0] bit_plane_sense_lines,
  // captured
  output logic      [WIDTH-1:0] hit
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_t;

  sync_t q_q;
  sync_t q_d;

  // ==================================================================
  // two flops per line, then the strobe window gates the second
  always_comb begin
    q_d    = q_q;
    q_d.s1 = bit_plane_sense_lines;
    q_d.s2 = q_q.s1;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q_q <= '0;
    end else begin
      q_q <= q_d;
    end
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign hit[i] = window & q_q.s2[i];
  end

endmodule : sense_capture

/* verilog/core_mem_ctrl.sv */
/*
  core memory cycle controller: the processor-side timing logic that runs
  read/regenerate and clear/write cycles against a clockless core module.
  assumes the core module decodes the address lines itself and that its
  sense outputs are valid pulses within the access time.
*/
// Notes on behaviour
// - controller gives address, direction and start
// - next cycle only after 1.69 us
// - write data driven within 0.7 us
// - controller holds data word and timing
// - write cycle clears, then writes word
// - read cycle reads, then regenerates word
// - twelve address lines held whole cycle
`timescale 1ns/10ps
module core_mem_ctrl #(
  parameter int unsigned CYCLE_CLKS  = core_mem_pkg::CYCLE_CLKS,
  parameter int unsigned ACCESS_CLKS = core_mem_pkg::ACCESS_CLKS,
  parameter int unsigned WDATA_CLKS  = core_mem_pkg::WDATA_CLKS
) (
  // clock and reset
  input  wire logic                                clk_sys,
  input  wire logic                                resetn,
  // user request
  input  wire core_mem_pkg::mem_req_t              req,
  output logic                                     req_ready,
  output core_mem_pkg::mem_rsp_t                   rsp,
  // memory pins
  output core_mem_pkg::core_pins_t                 pins,
  input  wire logic [core_mem_pkg::WORD_W-1:0]     bit_plane_sense_lines
);

  typedef struct packed {
    core_mem_pkg::state_t                 st;
    logic [core_mem_pkg::CNT_W-1:0]       cnt;
    logic                                 write;
    logic [core_mem_pkg::ADDR_W-1:0]      addr;
    logic [core_mem_pkg::WORD_W-1:0]      work;
    logic [core_mem_pkg::WORD_W-1:0]      wdata;
    logic                                 start;
    logic                                 drive;
    logic                                 done;
  } ctrl_t;

  localparam logic [core_mem_pkg::CNT_W-1:0] CNT_CYCLE  = core_mem_pkg::CNT_W'(CYCLE_CLKS - 1);
  localparam logic [core_mem_pkg::CNT_W-1:0] CNT_ACCESS = core_mem_pkg::CNT_W'(ACCESS_CLKS - 1);
  localparam logic [core_mem_pkg::CNT_W-1:0] CNT_WDATA  = core_mem_pkg::CNT_W'(WDATA_CLKS - 1);

  ctrl_t                            q_q;
  ctrl_t                            q_d;
  logic                             window;
  logic [core_mem_pkg::WORD_W-1:0]  hit;

  // ==================================================================
  // sense capture
  // sense is only looked at in the read half; clear-half pulses are dropped
  assign window = (q_q.st == core_mem_pkg::ST_FIRST) & ~q_q.write;

  sense_capture #(
    .WIDTH (core_mem_pkg::WORD_W)
  ) u_sense (
    .clk_sys               (clk_sys),
    .resetn                (resetn),
    .window                (window),
    .bit_plane_sense_lines (bit_plane_sense_lines),
    .hit                   (hit)
  );

  // ==================================================================
  // cycle sequencer
  always_comb begin
    q_d       = q_q;
    q_d.start = 1'b0;
    q_d.done  = 1'b0;
    q_d.cnt   = q_q.cnt + 1'b1;
    case (q_q.st)
      core_mem_pkg::ST_IDLE: begin
        q_d.cnt = '0;
        if (req.valid) begin
          q_d.st    = core_mem_pkg::ST_FIRST;
          q_d.start = 1'b1;
          q_d.write = req.write;
          q_d.addr  = req.addr;
          q_d.wdata = req.wdata;
          q_d.drive = 1'b0;
          // clear phase of write and read phase both start from a clear word
          q_d.work  = core_mem_pkg::WORD_RESET;
        end
      end
      core_mem_pkg::ST_FIRST: begin
        if (!q_q.write) begin
          q_d.work = q_q.work | hit;
        end
        // load: the cleared word stands until the last cycle of the clear half
        if (q_q.write && q_q.cnt == CNT_WDATA - 1'b1) begin
          q_d.work  = q_q.wdata;
          q_d.drive = 1'b1;
        end
        if (q_q.cnt == CNT_ACCESS) begin
          q_d.st    = core_mem_pkg::ST_LAST;
          q_d.drive = q_q.write ? q_q.drive : 1'b1;
        end
        if (q_q.write && q_q.cnt >= CNT_ACCESS) begin
          q_d.st = core_mem_pkg::ST_FIRST;
          if (q_q.cnt == CNT_WDATA) begin
            q_d.st = core_mem_pkg::ST_LAST;
          end
        end
      end
      core_mem_pkg::ST_LAST: begin
        // write or regenerate half runs out the rest of the cycle time
        if (q_q.cnt == CNT_CYCLE - 1'b1) begin
          q_d.st = core_mem_pkg::ST_DONE;
        end
      end
      core_mem_pkg::ST_DONE: begin
        q_d.st    = core_mem_pkg::ST_IDLE;
        q_d.done  = 1'b1;
        q_d.drive = 1'b0;
        q_d.cnt   = '0;
      end
      default: begin
        q_d = '0;
        q_d.st = core_mem_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q_q       <= '0;
      q_q.st    <= core_mem_pkg::ST_IDLE;
      q_q.addr  <= core_mem_pkg::ADDR_RESET;
      q_q.work  <= core_mem_pkg::WORD_RESET;
      q_q.wdata <= core_mem_pkg::WORD_RESET;
    end else begin
      q_q <= q_d;
    end
  end

  // ==================================================================
  // outputs
  // the core module decodes row and column itself; we only hold the lines
  assign pins.start      = q_q.start;
  assign pins.write      = q_q.write;
  assign pins.bank_sel   = q_q.addr[core_mem_pkg::ADDR_W-1];
  assign pins.addr       = q_q.addr[core_mem_pkg::BANK_ADDR_W-1:0];
  // low data bit drives inhibit on; core stores exactly the word
  assign pins.work       = q_q.work;
  assign pins.work_drive = q_q.drive;
  // ready is combinational so a waiting request goes in the first idle cycle
  assign req_ready       = (q_q.st == core_mem_pkg::ST_IDLE);
  assign rsp.done        = q_q.done;
  assign rsp.rdata       = q_q.work;

  // ==================================================================
  // checks
  // cycles since the last start, saturating so that it never wraps
  // starts saturated: reset aborts any cycle, so the first start owes no gap
  logic [core_mem_pkg::CNT_W:0] since_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      since_q <= '1;
    end else if (q_q.start) begin
      since_q <= '0;
    end else if (since_q != '1) begin
      since_q <= since_q + 1'b1;
    end
  end

  a_start_spacing: assert property (@(posedge clk_sys) disable iff (!resetn)
    q_q.start |-> ##1 (!q_q.start [*8]))
    else $error("start too soon");
  a_cycle_length: assert property (@(posedge clk_sys) disable iff (!resetn)
    q_d.start |-> (since_q >= CNT_CYCLE))
    else $error("cycle shorter than cycle time");
  a_addr_stable: assert property (@(posedge clk_sys) disable iff (!resetn)
    (q_q.st != core_mem_pkg::ST_IDLE && !q_q.start) |-> $stable(pins.addr))
    else $error("address changed in cycle");
  a_dir_stable: assert property (@(posedge clk_sys) disable iff (!resetn)
    (q_q.st != core_mem_pkg::ST_IDLE && !q_q.start) |-> $stable(pins.write))
    else $error("direction changed in cycle");
  a_wdata_time: assert property (@(posedge clk_sys) disable iff (!resetn)
    (q_q.start && q_q.write) |-> ##[1:14] (pins.work_drive && pins.work == q_q.wdata))
    else $error("write data late");
  a_read_regen: assert property (@(posedge clk_sys) disable iff (!resetn)
    (q_q.start && !q_q.write) |-> ##[1:11] pins.work_drive)
    else $error("no regenerate drive");
  a_done_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
    rsp.done |=> !rsp.done)
    else $error("done longer than one cycle");
  a_clear_start: assert property (@(posedge clk_sys) disable iff (!resetn)
    q_q.start |-> (!pins.work_drive && pins.work == core_mem_pkg::WORD_RESET))
    else $error("word not cleared at start");

  // clear half of a load: nothing is driven into the core for eight cycles
  a_clear_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    (q_q.start && q_q.write) |-> ##1 (!pins.work_drive [*8]))
    else $error("write data before clear");
  // sensing must be over within the access time, before regeneration
  a_sense_end: assert property (@(posedge clk_sys) disable iff (!resetn)
    (q_q.start && !q_q.write) |-> ##[1:10] (q_q.st == core_mem_pkg::ST_LAST))
    else $error("sense window too long");
  // the core is only fed from the working register inside a cycle
  a_idle_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
    (q_q.st == core_mem_pkg::ST_IDLE) |-> (!pins.work_drive && !pins.start))
    else $error("core driven while idle");

  c_read:  cover property (@(posedge clk_sys) q_q.start && !q_q.write);
  c_write: cover property (@(posedge clk_sys) q_q.start && q_q.write);
  c_bank1: cover property (@(posedge clk_sys) q_q.start && pins.bank_sel);
  c_b2b:   cover property (@(posedge clk_sys) rsp.done && req.valid);
  c_regen: cover property (@(posedge clk_sys) q_q.st == core_mem_pkg::ST_DONE && !q_q.write);

endmodule : core_mem_ctrl

/* dv/core_stack_model.sv */
/*
  behavioural core stack: 8192 twelve-bit words behind the controller pins.
  assumes pins change just after rising edges of clk_sys.
*/
`timescale 1ns/10ps
module core_stack_model (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  // controller pins
  input  wire core_mem_pkg::core_pins_t pins,
  // sense amplifiers
  output logic [11:0]                   bit_plane_sense_lines,
  // protocol faults seen on the pins
  output int                            faults
);
  // ==================================================================
  // storage
  logic [11:0] mem [0:8191];
  logic [12:0] sel_q;
  logic        wr_q;
  logic        drv_q;
  logic [11:0] word_q;
  int          gap_q;

  initial begin
    for (int i = 0; i < 8192; i++) mem[i] = 12'h000;
    gap_q  = 100;
    faults = 0;
    drv_q  = 1'b0;
    word_q = 12'h000;
  end

  // ==================================================================
  // cycle
  always @(posedge clk_sys) begin
    if (!resetn) begin
      // reset aborts any cycle: no spacing or hold is owed afterwards
      drv_q <= 1'b0;
      gap_q <= 100;
    end else begin
      drv_q <= pins.work_drive;
      gap_q <= gap_q + 1;
      if (pins.start) begin
        if (gap_q < 34) faults <= faults + 1;
        sel_q  <= {pins.bank_sel, pins.addr};
        wr_q   <= pins.write;
        word_q <= mem[{pins.bank_sel, pins.addr}];
        mem[{pins.bank_sel, pins.addr}] <= 12'h000;
        gap_q  <= 0;
      end else if (gap_q < 33 && {pins.bank_sel, pins.addr, pins.write} != {sel_q, wr_q}) begin
        faults <= faults + 1;
      end
      if (pins.work_drive) mem[sel_q] <= pins.work;
      if (pins.work_drive && !drv_q && wr_q && gap_q > 14) faults <= faults + 1;
    end
  end

  // pulses only on reads: the controller ignores sense during clear
  assign bit_plane_sense_lines = (!wr_q && gap_q < 4) ? word_q : 12'h000;
endmodule : core_stack_model

/* dv/tb_top.sv */
/*
  testbench for core_mem_ctrl against the behavioural core stack.
  assumes default timing parameters and a 20 MHz clock.
*/
`timescale 1ns/10ps
module tb_top;
  // ==================================================================
  // signals
  logic                     clk_sys;
  logic                     resetn;
  core_mem_pkg::mem_req_t   req;
  logic                     req_ready;
  core_mem_pkg::mem_rsp_t   rsp;
  core_mem_pkg::core_pins_t pins;
  logic [11:0]              sense;
  int                       faults;
  int                       miscompares;
  int                       cmp_count;
  int                       seed;
  logic [31:0]              r;
  logic [12:0]              note;
  logic [12:0]              notes [$];
  logic [11:0]              shadow [0:8191];
  logic [12:0]              edge_addr [4] = '{13'h0000, 13'h0fff, 13'h1000, 13'h1fff};
  logic [11:0]              edge_data [4] = '{12'hfff, 12'h000, 12'ha5a, 12'h5a5};

  core_mem_ctrl DUT (
    .clk_sys(clk_sys), .resetn(resetn), .req(req), .req_ready(req_ready),
    .rsp(rsp), .pins(pins), .bit_plane_sense_lines(sense));
  core_stack_model stack (
    .clk_sys(clk_sys), .resetn(resetn), .pins(pins), .bit_plane_sense_lines(sense),
    .faults(faults));

  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;

  // ==================================================================
  // tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic op(input logic w, input logic [12:0] a, input logic [11:0] d);
    int n;
    n = 0;
    @(negedge clk_sys);
    req = '{valid: 1'b1, write: w, addr: a, wdata: d};
    notes.push_back({~w, shadow[a]});
    if (w) shadow[a] = d;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 100) begin
      miscompares++;
      results();
    end
    @(posedge clk_sys);
  endtask : op

  task automatic drain();
    @(negedge clk_sys);
    req.valid = 1'b0;
    for (int n = 0; n < 100 && notes.size() > 0; n++) @(negedge clk_sys);
    if (notes.size() > 0) begin
      miscompares++;
      results();
    end
  endtask : drain

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // ==================================================================
  // result watcher: oldest note against each finished cycle
  always @(negedge clk_sys) begin
    if (rsp.done === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      if (note[12]) check("read word", {20'h0, rsp.rdata}, {20'h0, note[11:0]});
    end
  end

  // ==================================================================
  // stimulus
  initial begin
    seed        = 13083;
    resetn      = 1'b0;
    req         = '0;
    miscompares = 0;
    cmp_count   = 0;
    for (int i = 0; i < 8192; i++) shadow[i] = 12'h000;
    repeat (16) @(negedge clk_sys);
    resetn = 1'b1;
    // both banks at their ends; each word read twice to see regeneration
    foreach (edge_addr[i]) op(1'b1, edge_addr[i], edge_data[i]);
    foreach (edge_addr[i]) op(1'b0, edge_addr[i], 12'h000);
    foreach (edge_addr[i]) op(1'b0, edge_addr[i], 12'h000);
    $display("test bank edges done");
    // small address set so overwrites and rereads collide often
    repeat (60) begin
      r = $random(seed);
      op(r[13], {r[12], 7'h00, r[4:0]}, r[27:16]);
    end
    drain();
    $display("test random traffic done");
    // reset in mid-cycle, then recovery
    req = '{valid: 1'b1, write: 1'b0, addr: 13'h0abc, wdata: 12'h000};
    repeat (5) @(negedge clk_sys);
    resetn    = 1'b0;
    req.valid = 1'b0;
    @(negedge clk_sys);
    check("ready in reset", {31'h0, req_ready}, 32'h1);
    check("start in reset", {31'h0, pins.start}, 32'h0);
    repeat (40) @(negedge clk_sys);
    resetn = 1'b1;
    op(1'b1, 13'h1555, 12'h3c3);
    op(1'b0, 13'h1555, 12'h000);
    drain();
    $display("test mid-cycle reset done");
    check("pin protocol faults", faults, 32'h0);
    results();
  end

  // hang guard: about four times the expected run
  initial begin
    #(50 * 10000);
    miscompares++;
    results();
  end
endmodule : tb_top
